// ===== include/tec_pkg.sv
// Package: register map, field layout and reset values of the event counter
package tec_pkg;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'h0C;
   localparam logic [7:0] ADDR_COUNT_LOW  = 8'h0D;
   localparam logic [7:0] ADDR_CONTROL    = 8'h0E;
   localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h0F;
   localparam logic [7:0] ADDR_PIN_CTRL   = 8'h10;
   localparam logic [7:0] CONTROL_RESET   = 8'h08;
   localparam logic [7:0] CONTROL_WMASK   = 8'hDF;
   localparam int         POS_RUN         = 4;
   localparam int         POS_EDGE        = 3;
   localparam int         POS_FLAG        = 5;
   localparam int         POS_IRQ_EN      = 0;
   localparam int         POS_TONE_SEL    = 0;
   localparam int         POS_PIN_OUT     = 1;
   localparam int         POS_PIN_LATCH   = 2;
   localparam logic [1:0] MODE_EVENT      = 2'h1;
   localparam logic [1:0] MODE_TIMER      = 2'h2;
   localparam logic [1:0] MODE_PULSE      = 2'h3;
   localparam int         PRESCALE_W      = 7;

   typedef struct packed {
      logic [1:0] mode;
      logic       zero_bit;
      logic       run_bit;
      logic       edge_select;
      logic [2:0] prescale_select;
   } control_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;
endpackage : tec_pkg

// ===== rtl/tec_prescaler.sv
// Prescaler producing a one-cycle tick at the selected core clock division
module tec_prescaler (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [2:0] prescale_select,
   output logic            tick
);
   logic [tec_pkg::PRESCALE_W-1:0] count;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= count + 7'h01;
      end
   end

   // Divide 1,2,4,16,32,64,128; code 5 is undefined and gives no ticks
   always_comb begin
      unique case (prescale_select)
         3'h0: tick = 1'b1;
         3'h1: tick = (count[0] == 1'h1);
         3'h2: tick = (count[1:0] == 2'h3);
         3'h3: tick = (count[3:0] == 4'hF);
         3'h4: tick = (count[4:0] == 5'h1F);
         3'h6: tick = (count[5:0] == 6'h3F);
         3'h7: tick = (count == 7'h7F);
         default: tick = 1'b0;
      endcase
   end
endmodule : tec_prescaler

// ===== rtl/timer_event_counter.sv
// Sixteen-bit timer, event counter and pulse-width meter with register port
// Functional notes
// - Sixteen-bit up-counter clocked by pin edges or prescaled core clock.
// - Low byte write fills buffer; high byte write loads preload with buffer.
// - High byte read returns upper count, copies lower count into buffer.
// - Low byte read returns the holding buffer, not the live count.
// - Control bits 7:6 pick event, timer or pulse-width mode.
// - Event/timer count up; at all-ones reload preload and set flag.
// - Pulse mode starts on chosen edge, stops and clears run at return.
// - After one measurement, result held; edges ignored until run set.
// - Pulse mode starts only on an edge, never on a level.
// - Overflow during pulse measurement reloads and raises flag as usual.
// - Control bit 4 is run: one counts, zero stops.
// - Event and timer modes never clear run by themselves.
// - Overflow pulses a wake-up output for the halted core.
// - Clearing the overflow interrupt enable blocks the interrupt request.
// - Preload write while stopped also loads the counter.
// - High byte read blocks the counter clock for that cycle.
// - Bits 2:0 choose divide 1,2,4,16,32,64,128; code 101 undefined.
// - Control bit 3: zero rising active edge, one falling; pulse mode reverses this.
// - Control bit 5 is unused and reads zero.
// - Tone on pin output only when selected, output mode, latch one.
// - Tone toggles on each overflow, half the overflow rate.
//
// Our own choice: strobed register access.
module timer_event_counter (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic       event_input_pin,
   output logic [7:0]      rdata,
   output logic            overflow_irq,
   output logic            wake_up,
   output logic            tone_shared_pin,
   output logic            tone_shared_pin_oe_n
);
   tec_pkg::control_t counter_control;
   tec_pkg::bus_req_t req;
   logic [15:0] count;
   logic [15:0] preload;
   logic [7:0]  low_buffer;
   logic        overflow_flag;
   logic        overflow_irq_enable;
   logic        tone_select;
   logic        pin_is_output;
   logic        pin_latch;
   logic        overflow_tone;
   logic        pin_prev;
   logic        measuring;
   logic        tick;
   logic        rise;
   logic        fall;
   logic        active_edge;
   logic        step;
   logic        overflow;
   logic        measure_done;
   logic        blocked;
   logic        wr_high;
   logic        rd_high;
   logic        post_level;
   logic        pulse_mode;
   logic        fall_active;
   logic        ctrl_wr;

   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   function automatic logic hit(input tec_pkg::bus_req_t r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction : hit

   assign wr_high = req.wr && hit(req, tec_pkg::ADDR_COUNT_HIGH);
   assign rd_high = req.rd && hit(req, tec_pkg::ADDR_COUNT_HIGH);

   tec_prescaler u_prescaler (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .prescale_select (counter_control.prescale_select),
      .tick            (tick)
   );

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= event_input_pin;
      end
   end

   // Pin taken as synchronous; edges come from one registered copy
   assign rise        = event_input_pin && !pin_prev;
   assign fall        = !event_input_pin && pin_prev;
   // Pulse mode reads the edge bit the other way round from event mode
   assign pulse_mode  = (counter_control.mode == tec_pkg::MODE_PULSE);
   assign fall_active = counter_control.edge_select ^ pulse_mode;
   assign active_edge = fall_active ? fall : rise;
   assign post_level  = !fall_active;
   assign ctrl_wr     = req.wr && hit(req, tec_pkg::ADDR_CONTROL);
   assign blocked     = rd_high;

   // Count step by mode; run gates every mode
   always_comb begin
      step = 1'b0;
      if (counter_control.run_bit && !blocked) begin
         unique case (counter_control.mode)
            tec_pkg::MODE_EVENT: step = active_edge;
            tec_pkg::MODE_TIMER: step = tick;
            tec_pkg::MODE_PULSE: step = measuring && tick &&
                                        (event_input_pin == post_level);
            default: step = 1'b0;
         endcase
      end
   end

   assign overflow = step && (count == 16'hFFFF);

   // Measurement ends when the pin leaves the level after the start edge
   assign measure_done = (counter_control.mode == tec_pkg::MODE_PULSE) && measuring &&
                         counter_control.run_bit &&
                         (event_input_pin != post_level);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         measuring <= 1'b0;
      end else if (counter_control.mode != tec_pkg::MODE_PULSE ||
                   !counter_control.run_bit) begin
         measuring <= 1'b0;
      end else if (measure_done) begin
         measuring <= 1'b0;
      end else if (!measuring && active_edge) begin
         measuring <= 1'b1;
      end
   end

   // Control register; hardware clear of run only in pulse mode
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         counter_control <= tec_pkg::CONTROL_RESET;
      end else if (req.wr && hit(req, tec_pkg::ADDR_CONTROL)) begin
         counter_control <= req.wdata & tec_pkg::CONTROL_WMASK;
      end else if (measure_done) begin
         counter_control.run_bit <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         preload <= 16'h0000;
      end else if (wr_high) begin
         preload <= {req.wdata, low_buffer};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         low_buffer <= 8'h00;
      end else if (req.wr && hit(req, tec_pkg::ADDR_COUNT_LOW)) begin
         low_buffer <= req.wdata;
      end else if (rd_high) begin
         low_buffer <= count[7:0];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         count <= 16'h0000;
      end else if (wr_high && !counter_control.run_bit) begin
         count <= {req.wdata, low_buffer};
      end else if (overflow) begin
         count <= preload;
      end else if (step) begin
         count <= count + 16'h0001;
      end
   end

   // Interrupt control: hardware set beats software clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         overflow_flag       <= 1'b0;
         overflow_irq_enable <= 1'b0;
      end else begin
         if (req.wr && hit(req, tec_pkg::ADDR_IRQ_CTRL)) begin
            overflow_irq_enable <= req.wdata[tec_pkg::POS_IRQ_EN];
         end
         if (overflow) begin
            overflow_flag <= 1'b1;
         end else if (req.wr && hit(req, tec_pkg::ADDR_IRQ_CTRL)) begin
            overflow_flag <= req.wdata[tec_pkg::POS_FLAG];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         overflow_irq <= 1'b0;
         wake_up      <= 1'b0;
      end else begin
         overflow_irq <= (overflow_flag || overflow) && overflow_irq_enable;
         wake_up      <= overflow;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         overflow_tone <= 1'b0;
      end else if (overflow) begin
         overflow_tone <= !overflow_tone;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tone_select   <= 1'b0;
         pin_is_output <= 1'b0;
         pin_latch     <= 1'b1;
      end else if (req.wr && hit(req, tec_pkg::ADDR_PIN_CTRL)) begin
         tone_select   <= req.wdata[tec_pkg::POS_TONE_SEL];
         pin_is_output <= req.wdata[tec_pkg::POS_PIN_OUT];
         pin_latch     <= req.wdata[tec_pkg::POS_PIN_LATCH];
      end
   end

   // Latch gates the tone; input mode leaves the pin undriven
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tone_shared_pin      <= 1'b0;
         tone_shared_pin_oe_n <= 1'b1;
      end else begin
         tone_shared_pin_oe_n <= !pin_is_output;
         tone_shared_pin      <= tone_select ? (pin_latch && overflow_tone)
                                             : pin_latch;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            tec_pkg::ADDR_COUNT_HIGH: rdata <= count[15:8];
            tec_pkg::ADDR_COUNT_LOW:  rdata <= low_buffer;
            tec_pkg::ADDR_CONTROL:    rdata <= counter_control & tec_pkg::CONTROL_WMASK;
            tec_pkg::ADDR_IRQ_CTRL:   rdata <= {2'h0, overflow_flag, 4'h0,
                                                overflow_irq_enable};
            tec_pkg::ADDR_PIN_CTRL:   rdata <= {5'h00, pin_latch, pin_is_output,
                                                tone_select};
            default:                  rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Assertions
   a_overflow_reload: assert property (@(posedge clk_sys) disable iff (rst)
      overflow && !wr_high |=> count == $past(preload))
      else $error("count not reloaded on overflow");
   a_overflow_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
      overflow |=> overflow_flag)
      else $error("flag not set on overflow");
   a_high_read_buf: assert property (@(posedge clk_sys) disable iff (rst)
      rd_high |=> low_buffer == $past(count[7:0]) && rdata == $past(count[15:8]))
      else $error("high read capture wrong");
   a_read_blocks_count: assert property (@(posedge clk_sys) disable iff (rst)
      rd_high && !wr_high |=> count == $past(count))
      else $error("counter moved during high read");
   a_stopped_holds: assert property (@(posedge clk_sys) disable iff (rst)
      !counter_control.run_bit && !wr_high |=> $stable(count))
      else $error("counter moved while stopped");
   a_run_kept: assert property (@(posedge clk_sys) disable iff (rst)
      counter_control.run_bit && counter_control.mode != tec_pkg::MODE_PULSE &&
      !(req.wr && hit(req, tec_pkg::ADDR_CONTROL)) |=> counter_control.run_bit)
      else $error("run cleared by hardware");
   a_bit5_zero: assert property (@(posedge clk_sys) disable iff (rst)
      req.rd && hit(req, tec_pkg::ADDR_CONTROL) |=> rdata[5] == 1'b0)
      else $error("bit 5 read nonzero");
   a_tone_toggle: assert property (@(posedge clk_sys) disable iff (rst)
      overflow |=> overflow_tone != $past(overflow_tone))
      else $error("tone did not toggle");
   a_irq_masked: assert property (@(posedge clk_sys) disable iff (rst)
      !overflow_irq_enable |=> !overflow_irq)
      else $error("irq while disabled");
   a_stopped_load: assert property (@(posedge clk_sys) disable iff (rst)
      wr_high && !counter_control.run_bit |=> count == preload)
      else $error("stopped preload not loaded");

   // Pulse measurement steps and the low byte write
   sequence s_measure_end;
      measure_done && !ctrl_wr;
   endsequence
   sequence s_run_cleared;
      !counter_control.run_bit && !measuring;
   endsequence
   sequence s_pulse_idle;
      pulse_mode && counter_control.run_bit && !measuring && !active_edge;
   endsequence
   sequence s_low_fill;
      req.wr && hit(req, tec_pkg::ADDR_COUNT_LOW);
   endsequence

   a_wake_pulse: assert property (@(posedge clk_sys) disable iff (rst)
      overflow |=> wake_up)
      else $error("no wake pulse after overflow");
   a_wake_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      !overflow |=> !wake_up)
      else $error("wake pulse without overflow");
   a_pulse_stop: assert property (@(posedge clk_sys) disable iff (rst)
      s_measure_end |=> s_run_cleared)
      else $error("measurement end did not clear run");
   a_pulse_no_level: assert property (@(posedge clk_sys) disable iff (rst)
      s_pulse_idle |=> !measuring)
      else $error("measurement started without edge");
   a_done_ignores: assert property (@(posedge clk_sys) disable iff (rst)
      !counter_control.run_bit |=> !measuring)
      else $error("measuring while run is clear");
   a_pulse_hold: assert property (@(posedge clk_sys) disable iff (rst)
      pulse_mode && !measuring && !wr_high |=> $stable(count))
      else $error("pulse mode counted outside measurement");
   a_low_read_buf: assert property (@(posedge clk_sys) disable iff (rst)
      req.rd && hit(req, tec_pkg::ADDR_COUNT_LOW) |=> rdata == $past(low_buffer))
      else $error("low read not from buffer");
   a_preload_load: assert property (@(posedge clk_sys) disable iff (rst)
      wr_high |=> preload == {$past(req.wdata), $past(low_buffer)})
      else $error("preload not loaded from high write");
   a_low_write_only: assert property (@(posedge clk_sys) disable iff (rst)
      s_low_fill |=> $stable(preload) && low_buffer == $past(req.wdata))
      else $error("low write misrouted");
   a_pin_gate: assert property (@(posedge clk_sys) disable iff (rst)
      !pin_latch |=> !tone_shared_pin)
      else $error("pin high with latch clear");
   a_pin_drive: assert property (@(posedge clk_sys) disable iff (rst)
      pin_is_output |=> !tone_shared_pin_oe_n)
      else $error("pin not driven in output mode");
   a_code5_idle: assert property (@(posedge clk_sys) disable iff (rst)
      counter_control.prescale_select == 3'h5 && !wr_high &&
      counter_control.mode != tec_pkg::MODE_EVENT |=> $stable(count))
      else $error("undefined prescale code ticked");
   a_mode0_idle: assert property (@(posedge clk_sys) disable iff (rst)
      counter_control.mode == 2'h0 && !wr_high |=> $stable(count))
      else $error("unused mode counted");
   a_run_preload_only: assert property (@(posedge clk_sys) disable iff (rst)
      wr_high && counter_control.run_bit && !step |=> $stable(count))
      else $error("running counter loaded by preload write");
   a_count_up: assert property (@(posedge clk_sys) disable iff (rst)
      step && !overflow && !wr_high |=> count == $past(count) + 16'h0001)
      else $error("counter did not step by one");
   a_irq_raise: assert property (@(posedge clk_sys) disable iff (rst)
      overflow_flag && overflow_irq_enable |=> overflow_irq)
      else $error("enabled flag gave no request");
endmodule : timer_event_counter

// ===== sim/tec_pulse_src.sv
// Behavioural pulse source that stands on the event input pin
module tec_pulse_src (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       hold_high,
   input  wire logic       fire,
   input  wire logic [7:0] width,
   output logic            event_input_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] left;
   // Pin moves only just after a clock edge, as a synchronous source would
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         left <= 8'h00;
      end else if (fire) begin
         left <= width;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   assign event_input_pin = hold_high | (left != 8'h00);
endmodule : tec_pulse_src

// ===== sim/tb.sv
// Self-checking bench for the sixteen-bit timer and event counter
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys, rst, wr, rd, hold_high, fire, tone_q;
   logic [7:0]  addr, wdata, width, rdata, d;
   logic        overflow_irq, wake_up, tone_shared_pin, tone_shared_pin_oe_n, event_input_pin;
   logic [15:0] c, v;
   int          failures, compares, seed, wakes, tones, n;

   timer_event_counter timer_event_counter_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .event_input_pin(event_input_pin), .rdata(rdata),
      .overflow_irq(overflow_irq), .wake_up(wake_up), .tone_shared_pin(tone_shared_pin),
      .tone_shared_pin_oe_n(tone_shared_pin_oe_n));
   tec_pulse_src tec_pulse_src_inst (.clk_sys(clk_sys), .rst(rst), .hold_high(hold_high),
      .fire(fire), .width(width), .event_input_pin(event_input_pin));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Wake pulses and tone edges, counted for comparison with each other
   always @(posedge clk_sys) begin
      tone_q <= tone_shared_pin;
      if (wake_up === 1'b1) wakes++;
      if (tone_q !== tone_shared_pin) tones++;
   end

   function automatic logic [7:0] ctrl(logic [1:0] m, logic r, logic e, logic [2:0] p);
      return {m, 1'b0, r, e, p};
   endfunction : ctrl

   // Ticks expected in 258 cycles; code 5 never ticks
   function automatic int ticks(int k);
      int dv[8] = '{1, 2, 4, 16, 32, 0, 64, 128};
      return (dv[k] == 0) ? 0 : 258 / dv[k];
   endfunction : ticks

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Start and stop of a run cost a cycle or two, hence the slack
   task automatic near(input logic [15:0] got, input int exp);
      compares++;
      if ($isunknown(got) || got > exp + 2 || got + 2 < exp) begin
         failures++;
         $display("ERROR %0t got %0d expected near %0d", $time, got, exp);
      end
   endtask : near

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      wr <= 1'b1;
      addr <= a;
      wdata <= x;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_sys);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic wctl(input logic [7:0] x);
      wr_reg(tec_pkg::ADDR_CONTROL, x);
   endtask : wctl

   task automatic load(input logic [15:0] x);
      wr_reg(tec_pkg::ADDR_COUNT_LOW, x[7:0]);
      wr_reg(tec_pkg::ADDR_COUNT_HIGH, x[15:8]);
   endtask : load

   task automatic rd_count;
      rd_reg(tec_pkg::ADDR_COUNT_HIGH);
      c[15:8] = d;
      rd_reg(tec_pkg::ADDR_COUNT_LOW);
      c[7:0] = d;
   endtask : rd_count

   task automatic pulse(input int w, input int wt);
      @(posedge clk_sys);
      fire <= 1'b1;
      width <= w[7:0];
      @(posedge clk_sys);
      fire <= 1'b0;
      repeat (wt) @(posedge clk_sys);
   endtask : pulse

   initial begin
      #1000000;
      failures++;
      close_out;
   end

   initial begin
      seed = 32'h8f6753e5;
      failures = 0;
      compares = 0;
      {rst, wr, rd, hold_high, fire, addr, wdata, width} = {1'b1, 28'h0000000};
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      rd_reg(tec_pkg::ADDR_CONTROL);
      chk(d, tec_pkg::CONTROL_RESET);
      chk(tone_shared_pin_oe_n, 1'b1);
      rd_reg(8'h20);
      chk(d, 8'h00);
      wctl(8'hEF);
      rd_reg(tec_pkg::ADDR_CONTROL);
      chk(d, 8'hCF);
      v = 16'($random(seed));
      load(v);
      wr_reg(tec_pkg::ADDR_COUNT_LOW, ~v[7:0]);
      rd_count;
      chk(c, v);
      for (int k = 0; k < 8; k++) begin
         load(16'h0000);
         wctl(ctrl(tec_pkg::MODE_TIMER, 1'b1, 1'b0, k[2:0]));
         repeat (256) @(posedge clk_sys);
         wctl(ctrl(tec_pkg::MODE_TIMER, 1'b0, 1'b0, k[2:0]));
         rd_count;
         near(c, ticks(k));
      end
      v = c;
      repeat (20) @(posedge clk_sys);
      rd_count;
      chk(c, v);
      // Overflows with tone passing to the pin and the interrupt masked
      wr_reg(tec_pkg::ADDR_PIN_CTRL, 8'h07);
      wr_reg(tec_pkg::ADDR_IRQ_CTRL, 8'h00);
      load(16'hFFF0);
      wakes = 0;
      tones = 0;
      wctl(ctrl(tec_pkg::MODE_TIMER, 1'b1, 1'b0, 3'h0));
      repeat (100) @(posedge clk_sys);
      rd_reg(tec_pkg::ADDR_CONTROL);
      chk(d[tec_pkg::POS_RUN], 1'b1);
      wctl(ctrl(tec_pkg::MODE_TIMER, 1'b0, 1'b0, 3'h0));
      repeat (4) @(posedge clk_sys);
      near(wakes, 6);
      chk(tones, wakes);
      chk(tone_shared_pin_oe_n, 1'b0);
      rd_count;
      chk(c[15:4], 12'hFFF);
      rd_reg(tec_pkg::ADDR_IRQ_CTRL);
      chk(d[tec_pkg::POS_FLAG], 1'b1);
      chk(overflow_irq, 1'b0);
      wr_reg(tec_pkg::ADDR_IRQ_CTRL, 8'h21);
      repeat (2) @(posedge clk_sys);
      chk(overflow_irq, 1'b1);
      wr_reg(tec_pkg::ADDR_IRQ_CTRL, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(overflow_irq, 1'b0);
      // Latch at zero holds the pin low through overflows
      wr_reg(tec_pkg::ADDR_PIN_CTRL, 8'h03);
      repeat (2) @(posedge clk_sys);
      tones = 0;
      wctl(ctrl(tec_pkg::MODE_TIMER, 1'b1, 1'b0, 3'h0));
      repeat (60) @(posedge clk_sys);
      chk({tones[7:0], tone_shared_pin}, 9'h000);
      // Event counting on each edge, then unused mode 0; a final pulse cut short tells the two edges apart
      for (int eb = 0; eb < 3; eb++) begin
         wctl(ctrl(tec_pkg::MODE_EVENT, 1'b0, 1'b0, 3'h0));
         load(16'h0000);
         n = 1 + $unsigned($random(seed)) % 8;
         wctl(ctrl((eb == 2) ? 2'h0 : tec_pkg::MODE_EVENT, 1'b1, eb[0], 3'h0));
         for (int i = 0; i < n; i++) pulse(2 + $unsigned($random(seed)) % 4, 8);
         pulse(20, 5);
         wctl(ctrl(tec_pkg::MODE_EVENT, 1'b0, eb[0], 3'h0));
         rd_count;
         chk(c, (eb == 2) ? 0 : n + 1 - eb);
         repeat (20) @(posedge clk_sys);
      end
      // Pulse width: a level alone starts nothing, then one measurement only
      load(16'h0000);
      hold_high <= 1'b1;
      wctl(ctrl(tec_pkg::MODE_PULSE, 1'b1, 1'b1, 3'h0));
      repeat (10) @(posedge clk_sys);
      hold_high <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_count;
      chk(c, 16'h0000);
      n = 8 + $unsigned($random(seed)) % 32;
      pulse(n, n + 4);
      rd_count;
      near(c, n);
      v = c;
      rd_reg(tec_pkg::ADDR_CONTROL);
      chk(d[tec_pkg::POS_RUN], 1'b0);
      pulse(12, 16);
      rd_count;
      chk(c, v);
      // Flag left set by the timer runs; clear it so the next check can fail
      wr_reg(tec_pkg::ADDR_IRQ_CTRL, 8'h00);
      rd_reg(tec_pkg::ADDR_IRQ_CTRL);
      chk(d[tec_pkg::POS_FLAG], 1'b0);
      load(16'hFFF8);
      wctl(ctrl(tec_pkg::MODE_PULSE, 1'b1, 1'b1, 3'h0));
      pulse(30, 34);
      rd_reg(tec_pkg::ADDR_IRQ_CTRL);
      chk(d[tec_pkg::POS_FLAG], 1'b1);
      close_out;
   end
endmodule : tb
